// [hw/rrr_consts.vh]
// Constants for the rotate / return / repeat execution block
`ifndef RRR_CONSTS_VH
`define RRR_CONSTS_VH

// ==========================================================
// Register byte offsets
`define RRR_OFS_INSN 8'h00
`define RRR_OFS_STAT 8'h04
`define RRR_OFS_PC 8'h08
`define RRR_OFS_SW 8'h0C
`define RRR_OFS_SSW 8'h10
`define RRR_OFS_SVPC 8'h14
`define RRR_OFS_LINK 8'h18
`define RRR_OFS_RCTL 8'h1C
`define RRR_OFS_GPR 8'h40

// ==========================================================
// Status word fields
`define RRR_SW_T 0
`define RRR_SW_S 1
`define RRR_SW_RF_LO 2
`define RRR_SW_RF_HI 3
`define RRR_SW_MASKEV 28
`define RRR_SW_PRIV 30
`define RRR_SW_RESET 32'h50000000
`define RRR_MASK_CNT_REG 32'hF000FFF3
`define RRR_MASK_CNT_IMM 32'hF000FFFF
`define RRR_CNT_REG_BITS 32'h00000FFF
`define RRR_CNT_IMM_BITS 32'h000000FF

// ==========================================================
// Opcodes
`define RRR_OP_GRP4 4'h4
`define RRR_LO_ROT_LEFT 8'h04
`define RRR_LO_ROT_RIGHT 8'h05
`define RRR_LO_RCREG 8'h14
`define RRR_HI_RCIMM 8'h8A
`define RRR_OP_EXC_RET 16'h002B
`define RRR_OP_RTS 16'h000B
`define RRR_OP_SETS 16'h0058

// ==========================================================
// Cycle counts, PC and link offsets, and status register bits
`define RRR_CYC_ONE 3'h1
`define RRR_CYC_RTE 3'h4
`define RRR_CYC_RTS 3'h2
`define RRR_PC_STEP 32'h00000002
`define RRR_LINK_OFS 32'h00000004
`define RRR_ST_BUSY 0
`define RRR_ST_SLOT 1
`define RRR_ST_ILL 2
`define RRR_ST_SLOTILL 3
`define RRR_ST_REFUSED 4
`define RRR_ST_IRQ 5

`endif

// [hw/rrr_rotator.v]
// Single-bit rotate unit, left or right, with the bit shifted out
module rrr_rotator #(
	parameter W = 32
) (
	input wire [W-1:0] val_i, // Operand
	input wire right_i, // 1 rotates right
	output wire [W-1:0] res_o, // Rotated value
	output wire flag_o // Bit that went round
);
	assign res_o = right_i ? {val_i[0], val_i[W-1:1]} : {val_i[W-2:0], val_i[W-1]};
	assign flag_o = right_i ? val_i[0] : val_i[W-1];
endmodule // rrr_rotator

// [hw/rrr_cycle_timer.v]
// Down counter that holds an instruction for its cycle count
module rrr_cycle_timer #(
	parameter CW = 3
) (
	input wire clk_i, // Clock
	input wire rst_i, // Synchronous reset
	input wire start_i, // Load the count
	input wire [CW-1:0] len_i, // Cycles to run, at least one
	output wire run_o, // Instruction in flight
	output wire done_o // Last cycle of the instruction
);
	reg [CW-1:0] cnt_q;
	reg run_q;

	always @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= {CW{1'b0}};
			run_q <= 1'b0;
		end else if (start_i) begin
			cnt_q <= len_i;
			run_q <= 1'b1;
		end else if (run_q) begin
			cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
			if (cnt_q == {{(CW-1){1'b0}}, 1'b1}) begin
				run_q <= 1'b0;
			end
		end
	end

	assign run_o = run_q;
	assign done_o = run_q && (cnt_q == {{(CW-1){1'b0}}, 1'b1});
endmodule // rrr_cycle_timer

// [hw/rrr_exec.v]
// Execution block for rotate, return, repeat-count load and saturation set
`include "rrr_consts.vh"

module rrr_exec #(
	parameter NREG = 16
) (
	input wire clk_i, // Clock, 40 MHz
	input wire rst_i, // Synchronous reset, active high
	input wire wb_cyc_i, // Wishbone cycle
	input wire wb_stb_i, // Wishbone strobe
	input wire wb_we_i, // Wishbone write enable
	input wire [7:0] wb_adr_i, // Wishbone byte address
	input wire [3:0] wb_sel_i, // Wishbone byte selects
	input wire [31:0] wb_dat_i, // Wishbone write data
	output reg [31:0] wb_dat_o, // Wishbone read data
	output reg wb_ack_o, // Wishbone acknowledge
	input wire irq_i, // Interrupt request pin
	output reg irq_accept_o // Interrupt may be taken now
);
	// ==========================================================
	// Decode helpers
	function is_rot_left;
		input [15:0] o;
		is_rot_left = (o[15:12] == `RRR_OP_GRP4) && (o[7:0] == `RRR_LO_ROT_LEFT);
	endfunction

	function is_rot_right;
		input [15:0] o;
		is_rot_right = (o[15:12] == `RRR_OP_GRP4) && (o[7:0] == `RRR_LO_ROT_RIGHT);
	endfunction

	function is_rcreg;
		input [15:0] o;
		is_rcreg = (o[15:12] == `RRR_OP_GRP4) && (o[7:0] == `RRR_LO_RCREG);
	endfunction

	function is_rcimm;
		input [15:0] o;
		is_rcimm = (o[15:8] == `RRR_HI_RCIMM);
	endfunction

	function [2:0] op_len;
		input [15:0] o;
		begin
			if (o == `RRR_OP_EXC_RET) begin
				op_len = `RRR_CYC_RTE;
			end else if (o == `RRR_OP_RTS) begin
				op_len = `RRR_CYC_RTS;
			end else begin
				op_len = `RRR_CYC_ONE;
			end
		end
	endfunction

	function [31:0] merge_sel;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] sel;
		integer b;
		begin
			merge_sel = old;
			for (b = 0; b < 4; b = b + 1) begin
				if (sel[b]) begin
					merge_sel[b*8 +: 8] = nw[b*8 +: 8];
				end
			end
		end
	endfunction

	// ==========================================================
	// State
	reg [31:0] gpr_q [0:NREG-1];
	reg [31:0] pc_q;
	reg [31:0] sw_q;
	reg [31:0] ssw_q;
	reg [31:0] svpc_q;
	reg [31:0] link_q;
	reg [1:0] rctl_q;
	reg [15:0] op_q;
	reg slot_q;
	reg [31:0] target_q;
	reg ill_q;
	reg slotill_q;
	reg refused_q;
	reg irq_seen_q;
	reg irq_s1_q;
	reg irq_s2_q;
	integer i;

	wire bus_req = wb_cyc_i && wb_stb_i;
	wire wr_now = bus_req && wb_we_i && wb_ack_o;
	wire gpr_hit = ((wb_adr_i & 8'hC0) == `RRR_OFS_GPR);
	wire [3:0] gpr_idx = wb_adr_i[5:2];
	wire run;
	wire done;
	wire issue = wr_now && (wb_adr_i == `RRR_OFS_INSN) && !run;
	wire [3:0] dst_idx = op_q[11:8];
	wire [31:0] rot_res;
	wire rot_flag;
	wire op_branch = (op_q == `RRR_OP_EXC_RET) || (op_q == `RRR_OP_RTS);
	wire [31:0] stat_word = {26'h0, irq_seen_q, refused_q, slotill_q, ill_q, slot_q, run};
	wire can_irq = irq_s2_q && !run && !issue && !slot_q && !sw_q[`RRR_SW_MASKEV];

	// ==========================================================
	// Units
	rrr_cycle_timer #(
		.CW(3)
	) u_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(issue),
		.len_i(op_len(wb_dat_i[15:0])),
		.run_o(run),
		.done_o(done)
	);

	rrr_rotator #(
		.W(32)
	) u_rot (
		.val_i(gpr_q[dst_idx]),
		.right_i(is_rot_right(op_q)),
		.res_o(rot_res),
		.flag_o(rot_flag)
	);

	// ==========================================================
	// Wishbone slave: answer one cycle after the request, hold data with ack
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= bus_req && !wb_ack_o;
			if (bus_req && !wb_ack_o) begin
				if (gpr_hit) begin
					wb_dat_o <= gpr_q[gpr_idx];
				end else begin
					case (wb_adr_i)
						`RRR_OFS_INSN: wb_dat_o <= {16'h0000, op_q};
						`RRR_OFS_STAT: wb_dat_o <= stat_word;
						`RRR_OFS_PC: wb_dat_o <= pc_q;
						`RRR_OFS_SW: wb_dat_o <= sw_q;
						`RRR_OFS_SSW: wb_dat_o <= ssw_q;
						`RRR_OFS_SVPC: wb_dat_o <= svpc_q;
						`RRR_OFS_LINK: wb_dat_o <= link_q;
						`RRR_OFS_RCTL: wb_dat_o <= {30'h0, rctl_q};
						default: wb_dat_o <= 32'h00000000;
					endcase
				end
			end
		end
	end

	// ==========================================================
	// Interrupt pin synchroniser and acceptance window
	always @(posedge clk_i) begin
		if (rst_i) begin
			irq_s1_q <= 1'b0;
			irq_s2_q <= 1'b0;
			irq_accept_o <= 1'b0;
		end else begin
			irq_s1_q <= irq_i;
			irq_s2_q <= irq_s1_q;
			irq_accept_o <= can_irq;
		end
	end

	// ==========================================================
	// Architectural state: bus writes first, instruction commit overrides
	always @(posedge clk_i) begin
		if (rst_i) begin
			for (i = 0; i < NREG; i = i + 1) begin
				gpr_q[i] <= 32'h00000000;
			end
			pc_q <= 32'h00000000;
			sw_q <= `RRR_SW_RESET;
			ssw_q <= 32'h00000000;
			svpc_q <= 32'h00000000;
			link_q <= 32'h00000000;
			rctl_q <= 2'h0;
			op_q <= 16'h0000;
			slot_q <= 1'b0;
			target_q <= 32'h00000000;
			ill_q <= 1'b0;
			slotill_q <= 1'b0;
			refused_q <= 1'b0;
			irq_seen_q <= 1'b0;
		end else begin
			if (wr_now) begin
				if (gpr_hit) begin
					gpr_q[gpr_idx] <= merge_sel(gpr_q[gpr_idx], wb_dat_i, wb_sel_i);
				end else begin
					case (wb_adr_i)
						`RRR_OFS_STAT: begin
							// Write one to clear; a same-cycle event below still sets
							if (wb_sel_i[0] && wb_dat_i[`RRR_ST_ILL]) ill_q <= 1'b0;
							if (wb_sel_i[0] && wb_dat_i[`RRR_ST_SLOTILL]) slotill_q <= 1'b0;
							if (wb_sel_i[0] && wb_dat_i[`RRR_ST_REFUSED]) refused_q <= 1'b0;
							if (wb_sel_i[0] && wb_dat_i[`RRR_ST_IRQ]) irq_seen_q <= 1'b0;
						end
						`RRR_OFS_PC: pc_q <= merge_sel(pc_q, wb_dat_i, wb_sel_i);
						`RRR_OFS_SW: sw_q <= merge_sel(sw_q, wb_dat_i, wb_sel_i);
						`RRR_OFS_SSW: ssw_q <= merge_sel(ssw_q, wb_dat_i, wb_sel_i);
						`RRR_OFS_SVPC: svpc_q <= merge_sel(svpc_q, wb_dat_i, wb_sel_i);
						`RRR_OFS_LINK: link_q <= merge_sel(link_q, wb_dat_i, wb_sel_i);
						`RRR_OFS_RCTL: if (wb_sel_i[0]) rctl_q <= wb_dat_i[1:0];
						default: ;
					endcase
				end
			end
			if (wr_now && (wb_adr_i == `RRR_OFS_INSN)) begin
				if (run) begin
					refused_q <= 1'b1;
				end else begin
					op_q <= wb_dat_i[15:0];
				end
			end
			if (can_irq) begin
				irq_seen_q <= 1'b1;
			end
			if (done) begin
				if (slot_q && op_branch) begin
					// Exception taken instead: the pending branch is dropped
					slotill_q <= 1'b1;
					slot_q <= 1'b0;
				end else if (op_q == `RRR_OP_EXC_RET && !sw_q[`RRR_SW_PRIV]) begin
					ill_q <= 1'b1;
				end else begin
					if (op_q == `RRR_OP_EXC_RET) begin
						// Status restored now so the slot runs under it
						sw_q <= ssw_q;
						target_q <= svpc_q;
						slot_q <= 1'b1;
						pc_q <= pc_q + `RRR_PC_STEP;
					end else if (op_q == `RRR_OP_RTS) begin
						target_q <= link_q + `RRR_LINK_OFS;
						slot_q <= 1'b1;
						pc_q <= pc_q + `RRR_PC_STEP;
					end else if (slot_q) begin
						pc_q <= target_q;
						slot_q <= 1'b0;
					end else begin
						pc_q <= pc_q + `RRR_PC_STEP;
					end
					if (is_rot_left(op_q) || is_rot_right(op_q)) begin
						gpr_q[dst_idx] <= rot_res;
						sw_q[`RRR_SW_T] <= rot_flag;
					end else if (op_q == `RRR_OP_SETS) begin
						sw_q[`RRR_SW_S] <= 1'b1;
					end else if (is_rcreg(op_q)) begin
						sw_q <= (sw_q & `RRR_MASK_CNT_REG) | ((gpr_q[dst_idx] & `RRR_CNT_REG_BITS) << 16)
							| ({30'h0, rctl_q} << `RRR_SW_RF_LO);
					end else if (is_rcimm(op_q)) begin
						sw_q <= ((sw_q & `RRR_MASK_CNT_IMM) & ~(32'h00000003 << `RRR_SW_RF_LO))
							| (({24'h000000, op_q[7:0]} & `RRR_CNT_IMM_BITS) << 16)
							| ({30'h0, rctl_q} << `RRR_SW_RF_LO);
					end else if (!op_branch) begin
						ill_q <= 1'b1;
					end
				end
			end
		end
	end
endmodule // rrr_exec

// [sim/rrr_exec_chk.sv]
// Checker for bus handshake and interrupt gating of the execution block
module rrr_exec_chk #(
	parameter NREG = 16
) (
	input wire clk_i, // Clock
	input wire rst_i, // Reset
	input wire wb_cyc_i, // Cycle
	input wire wb_stb_i, // Strobe
	input wire wb_we_i, // Write
	input wire [7:0] wb_adr_i, // Address
	input wire [3:0] wb_sel_i, // Lanes
	input wire [31:0] wb_dat_i, // Write data
	input wire [31:0] wb_dat_o, // Read data
	input wire wb_ack_o, // Acknowledge
	input wire irq_i, // Interrupt pin
	input wire irq_accept_o // Interrupt window
);
	// ==========
	// Properties
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	wire req = wb_cyc_i && wb_stb_i;
	sequence s_take;
		req && !wb_ack_o;
	endsequence
	sequence s_rts;
		wb_ack_o && wb_we_i && wb_adr_i == 8'h00 && wb_dat_i[15:0] == 16'h000B;
	endsequence
	property p_ack;
		s_take |=> wb_ack_o;
	endproperty
	property p_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	property p_noreq;
		!req |=> !wb_ack_o;
	endproperty
	property p_unmap;
		s_take ##0 (!wb_we_i && wb_adr_i[7]) |=> wb_dat_o == 32'h00000000;
	endproperty
	property p_irq_off;
		!irq_i [*4] |=> !irq_accept_o;
	endproperty
	property p_irq_src;
		$rose(irq_accept_o) |-> $past(irq_i, 2) || $past(irq_i, 3) || $past(irq_i, 4);
	endproperty
	// The return is still in flight for two cycles, so no interrupt window
	property p_rts_irq;
		s_rts |=> ##1 !irq_accept_o [*2];
	endproperty
	property p_rst;
		$fell(rst_i) |-> !wb_ack_o && !irq_accept_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack missing after request");
	a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
	a_noreq: assert property (p_noreq) else $error("ack without request");
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	a_irq_off: assert property (p_irq_off) else $error("window open without request");
	a_irq_src: assert property (p_irq_src) else $error("window opened without pin");
	a_rts_irq: assert property (p_rts_irq) else $error("window open after return");
	a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule // rrr_exec_chk

// [sim/testbench.sv]
// Self-checking bench for the rotate, return and repeat execution block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Signals
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, irq = 0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] wdat = 32'h00000000, rdat;
	wire [31:0] dat_o;
	wire ack, acc;
	int error_cnt = 0, n_tests = 0;
	logic [15:0] rop [3] = '{16'h4104, 16'h4105, 16'h4105};
	logic [31:0] rv [3] = '{32'h00000005, 32'h80000002, 32'h40000001};
	logic [31:0] rs [3] = '{32'h50000001, 32'h50000001, 32'h50000000};
	always #12.5 clk_i = ~clk_i;
	rrr_exec #(.NREG(16)) u_rrr_exec (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .irq_i(irq), .irq_accept_o(acc));
	// ==========
	// Bus tasks
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		@(posedge clk_i);
		while (ack !== 1'b1 && k < 20) begin
			@(posedge clk_i);
			k++;
		end
		if (k == 20) error_cnt++;
		rdat = dat_o;
		cyc <= 0;
		stb <= 0;
		@(posedge clk_i);
	endtask
	task ck(input logic [7:0] a, input logic [31:0] e, input string nm);
		bus(0, a, 32'h00000000);
		chk(nm, e, rdat);
	endtask
	// Polls busy only; a pending slot stays visible in the status
	task issue(input logic [15:0] op);
		bus(1, 8'h00, {16'h0000, op});
		repeat (10) begin
			bus(0, 8'h04, 32'h00000000);
			if (rdat[0] === 1'b0) break;
		end
	endtask
	// ==========
	// Scenarios
	task t_reset;
		ck(8'h0C, 32'h50000000, "sw");
		ck(8'h04, 32'h00000000, "stat");
		bus(1, 8'h80, 32'hFFFFFFFF);
		ck(8'h80, 32'h00000000, "unmapped");
		chk("accept reset", 32'h0, {31'h0, acc});
		$display("test reset done");
	endtask
	task t_rot;
		bus(1, 8'h44, 32'h80000002);
		bus(1, 8'h08, 32'h00000000);
		for (int i = 0; i < 3; i++) begin
			issue(rop[i]);
			ck(8'h44, rv[i], "rot value");
			ck(8'h0C, rs[i], "rot flag");
		end
		ck(8'h08, 32'h00000006, "rot pc");
		$display("test rotate done");
	endtask
	task t_repeat;
		bus(1, 8'h0C, 32'hFFFFFFFF);
		bus(1, 8'h4C, 32'hFFFFABCD);
		bus(1, 8'h1C, 32'h00000002);
		issue(16'h4314);
		ck(8'h0C, 32'hFBCDFFFB, "count reg");
		bus(1, 8'h1C, 32'h00000001);
		issue(16'h8A5A);
		ck(8'h0C, 32'hF05AFFF7, "count imm");
		bus(1, 8'h0C, 32'h50000000);
		issue(16'h0058);
		ck(8'h0C, 32'h50000002, "sat");
		$display("test repeat done");
	endtask
	task t_exc_ret;
		bus(1, 8'h10, 32'h00000000);
		bus(1, 8'h14, 32'h00000100);
		bus(1, 8'h48, 32'h00000001);
		bus(1, 8'h08, 32'h00000020);
		bus(1, 8'h00, 32'h0000002B);
		issue(16'h4104);
		ck(8'h04, 32'h00000012, "eret stat");
		ck(8'h0C, 32'h00000000, "eret sw");
		ck(8'h08, 32'h00000022, "eret pc");
		bus(1, 8'h14, 32'h00000200);
		issue(16'h4205);
		ck(8'h0C, 32'h00000001, "slot sw");
		ck(8'h08, 32'h00000100, "slot pc");
		chk("accept open", 32'h1, {31'h0, acc});
		ck(8'h04, 32'h00000030, "irq seen");
		bus(1, 8'h04, 32'h0000003C);
		issue(16'h002B);
		bus(0, 8'h04, 32'h00000000);
		chk("user eret", 32'h4, {28'h0, rdat[3:0]});
		ck(8'h08, 32'h00000100, "user pc");
		$display("test exception return done");
	endtask
	task t_rts;
		irq <= 0;
		bus(1, 8'h18, 32'h00000300);
		bus(1, 8'h04, 32'h0000003C);
		issue(16'h000B);
		issue(16'h000B);
		bus(0, 8'h04, 32'h00000000);
		chk("nested", 32'h8, {28'h0, rdat[3:0]});
		bus(1, 8'h04, 32'h0000003C);
		issue(16'h000B);
		bus(1, 8'h18, 32'h00000500);
		issue(16'h0058);
		ck(8'h08, 32'h00000304, "rts pc");
		ck(8'h0C, 32'h00000003, "rts slot");
		chk("accept idle", 32'h0, {31'h0, acc});
		$display("test subroutine return done");
	endtask
	task results;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ==========
	// Sequence
	initial begin
		repeat (10) @(posedge clk_i);
		rst_i <= 0;
		irq <= 1;
		@(posedge clk_i);
		t_reset;
		t_rot;
		t_repeat;
		t_exc_ret;
		t_rts;
		results;
	end
	// Far above the few hundred cycles the sequence needs
	initial begin
		#(25 * 5000);
		error_cnt++;
		results;
	end
endmodule // testbench

bind rrr_exec rrr_exec_chk #(.NREG(NREG)) u_rrr_exec_chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.irq_i(irq_i), .irq_accept_o(irq_accept_o));
